// ---- splc_pkg.sv ----
package splc_pkg;
  // Register offsets (word indices on the plain register port)
  localparam logic [3:0] ADDR_SP = 4'h0;
  localparam logic [3:0] ADDR_LIMIT = 4'h1;
  localparam logic [3:0] ADDR_TRAP = 4'h2;
  localparam logic [3:0] ADDR_IRQ_STAT = 4'h3;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h4;
  // Field positions
  localparam int FAULT_BIT = 2;
  localparam int EV_OVER = 0;
  localparam int EV_UNDER = 1;
  localparam int PC_TOP = 6;
  // Values
  localparam logic [15:0] SP_RESET = 16'h0800;
  localparam logic [15:0] SP_FLOOR = 16'h0800;
  localparam logic [15:0] WORD_STEP = 16'h0002;
  localparam logic [15:0] ALIGN_MASK = 16'hfffe;
  localparam logic [15:0] ZERO16 = 16'h0000;
  localparam logic [1:0] ZERO2 = 2'h0;
  // Stack operation codes from the sequencer
  typedef enum logic [1:0] {SPLC_OP_NONE, SPLC_OP_PUSH, SPLC_OP_POP, SPLC_OP_EA} splc_op_t;
  // Pushed-word source selection
  typedef enum logic [1:0] {SPLC_SRC_DATA, SPLC_SRC_CALL, SPLC_SRC_EXC} splc_src_t;
  // Word-align any stack address
  function automatic logic [15:0] splc_align(input logic [15:0] a);
    return a & ALIGN_MASK;
  endfunction : splc_align
endpackage : splc_pkg

// ---- splc_push_fmt.sv ----
`timescale 1ns/1ps
// Forms the word written on a push
module splc_push_fmt import splc_pkg::*; (
  // Selection
  input wire splc_src_t src,
  // Sources
  input wire logic [15:0] data,
  input wire logic [22:0] pc,
  input wire logic [7:0] status_low_byte,
  // Result: low word and high word of a program counter push
  output logic [15:0] word_lo,
  output logic [15:0] word_hi
);
  // Combinational formatting
  always_comb begin
    word_lo = data;
    word_hi = ZERO16;
    unique case (src)
      SPLC_SRC_CALL: begin
        word_lo = {pc[15:1], 1'b0};
        word_hi = {9'h0, pc[22:16]}; // RULE_03
      end
      SPLC_SRC_EXC: begin
        word_lo = {pc[15:1], 1'b0};
        word_hi = {status_low_byte, 1'b0, pc[22:16]}; // RULE_04
      end
      default: begin
        word_lo = data;
        word_hi = ZERO16;
      end
    endcase
  end
endmodule : splc_push_fmt

// ---- splc_check.sv ----
`timescale 1ns/1ps
// Limit and floor comparison of one stack address
module splc_check import splc_pkg::*; (
  // Address and bounds
  input wire logic [15:0] addr,
  input wire logic [15:0] limit,
  // Results
  output logic over,
  output logic under
);
  // Upper limit and fixed floor
  always_comb begin
    over = addr > limit; // RULE_08
    under = addr < SP_FLOOR; // RULE_09
  end
endmodule : splc_check

// ---- splc_stack_limit.sv ----
// The placing of the registers and strobed register access were decided locally.
`timescale 1ns/1ps
// Functional notes
// RULE_01: Pointer holds next free word, grows upward
// RULE_02: Push writes then increments; pop decrements first
// RULE_03: Call push clears counter top bit
// RULE_04: Exception push adds status low byte
// RULE_05: Limit register has no reset value
// RULE_06: Limit bit zero always reads zero
// RULE_07: Every pointer-based address checked against limit
// RULE_08: Push at limit fine; next push traps
// RULE_09: Address below floor raises stack trap
// RULE_10: Avoid pointer read right after limit write
// RULE_11: Trap sets fault flag bit two
// RULE_12: Flag holds until software writes zero
module splc_stack_limit import splc_pkg::*; (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Stack sequencer request
  input wire splc_op_t op,
  input wire splc_src_t push_src,
  input wire logic [15:0] push_data,
  input wire logic [22:0] pc,
  input wire logic [7:0] status_low_byte,
  input wire logic [15:0] ea_addr,
  // Memory access answer
  output logic mem_we,
  output logic mem_re,
  output logic [15:0] mem_addr,
  output logic [15:0] mem_wdata,
  output logic [15:0] mem_wdata_hi,
  // Trap and interrupt
  output logic stack_trap,
  output logic irq
);
  // All block state
  typedef struct packed {
    logic [15:0] sp;
    logic [15:0] limit;
    logic fault;
    logic [1:0] ev_stat;
    logic [1:0] ev_mask;
    logic [15:0] rdata;
    logic we;
    logic re;
    logic [15:0] maddr;
    logic [15:0] wdata;
    logic [15:0] wdata_hi;
    logic trap;
    logic irq;
  } splc_state_t;

  splc_state_t cur; // Registered state
  splc_state_t next_st; // Next state
  logic [15:0] fmt_lo; // Formatted push low word
  logic [15:0] fmt_hi; // Formatted push high word
  logic [15:0] chk_addr; // Address under check
  logic chk_over; // Above limit
  logic chk_under; // Below floor
  logic [15:0] pop_addr; // Pre-decremented pointer

  // Push word formatter
  splc_push_fmt u_fmt (
    .src(push_src),
    .data(push_data),
    .pc(pc),
    .status_low_byte(status_low_byte),
    .word_lo(fmt_lo),
    .word_hi(fmt_hi)
  );

  // Address selection for the comparator
  always_comb begin
    pop_addr = cur.sp - WORD_STEP; // RULE_02
    unique case (op)
      SPLC_OP_PUSH: chk_addr = cur.sp;
      SPLC_OP_POP: chk_addr = pop_addr;
      SPLC_OP_EA: chk_addr = splc_align(ea_addr);
      default: chk_addr = cur.sp;
    endcase
  end

  // Limit and floor comparator
  splc_check u_chk (
    .addr(chk_addr),
    .limit(cur.limit),
    .over(chk_over),
    .under(chk_under)
  );

  // Next-state logic
  always_comb begin
    logic active;
    logic err_over;
    logic err_under;
    logic rd_stat;
    active = 1'b0;
    err_over = 1'b0;
    err_under = 1'b0;
    rd_stat = 1'b0;
    next_st = cur;
    next_st.we = 1'b0;
    next_st.re = 1'b0;
    next_st.trap = 1'b0;
    next_st.rdata = ZERO16;
    active = (op != SPLC_OP_NONE);
    // Every pointer-based address is compared
    err_over = active && chk_over; // RULE_07
    err_under = active && chk_under; // RULE_09
    // Stack operations
    unique case (op)
      SPLC_OP_PUSH: begin
        next_st.we = 1'b1;
        next_st.maddr = cur.sp; // RULE_02
        next_st.wdata = fmt_lo;
        next_st.wdata_hi = fmt_hi;
        next_st.sp = splc_align(cur.sp + WORD_STEP); // RULE_01
      end
      SPLC_OP_POP: begin
        next_st.re = 1'b1;
        next_st.sp = splc_align(pop_addr); // RULE_02
        next_st.maddr = pop_addr;
      end
      SPLC_OP_EA: begin
        next_st.maddr = splc_align(ea_addr);
      end
      default: begin
        next_st.maddr = cur.maddr;
      end
    endcase
    // Register read, data one cycle later
    if (reg_rd) begin
      unique case (reg_addr)
        ADDR_SP: next_st.rdata = cur.sp;
        ADDR_LIMIT: next_st.rdata = splc_align(cur.limit); // RULE_06
        ADDR_TRAP: next_st.rdata = {13'h0, cur.fault, ZERO2}; // RULE_11
        ADDR_IRQ_STAT: begin
          next_st.rdata = {14'h0, cur.ev_stat};
          rd_stat = 1'b1;
        end
        ADDR_IRQ_MASK: next_st.rdata = {14'h0, cur.ev_mask};
        default: next_st.rdata = ZERO16;
      endcase
    end
    // Read of status clears it
    if (rd_stat) begin
      next_st.ev_stat = 2'h0;
    end
    // Register writes
    if (reg_wr) begin
      unique case (reg_addr)
        ADDR_SP: next_st.sp = splc_align(reg_wdata);
        ADDR_LIMIT: next_st.limit = splc_align(reg_wdata); // RULE_06
        ADDR_TRAP: next_st.fault = reg_wdata[FAULT_BIT] & cur.fault; // RULE_12
        ADDR_IRQ_MASK: next_st.ev_mask = reg_wdata[1:0];
        default: next_st.ev_mask = next_st.ev_mask;
      endcase
    end
    // Errors set flags; set wins over clear
    if (err_over || err_under) begin
      next_st.fault = 1'b1; // RULE_11
      next_st.trap = 1'b1;
    end
    if (err_over) begin
      next_st.ev_stat[EV_OVER] = 1'b1;
    end
    if (err_under) begin
      next_st.ev_stat[EV_UNDER] = 1'b1;
    end
    next_st.irq = |(next_st.ev_stat & next_st.ev_mask);
  end

  // State register; limit has no reset
  always_ff @(posedge clock) begin
    if (!rstn) begin
      cur.sp <= SP_RESET;
      cur.fault <= 1'b0;
      cur.ev_stat <= 2'h0;
      cur.ev_mask <= 2'h0;
      cur.rdata <= ZERO16;
      cur.we <= 1'b0;
      cur.re <= 1'b0;
      cur.maddr <= ZERO16;
      cur.wdata <= ZERO16;
      cur.wdata_hi <= ZERO16;
      cur.trap <= 1'b0;
      cur.irq <= 1'b0;
      cur.limit <= next_st.limit; // RULE_05
    end else begin
      cur <= next_st;
    end
  end

  // Outputs straight from flip-flops
  assign reg_rdata = cur.rdata;
  assign mem_we = cur.we;
  assign mem_re = cur.re;
  assign mem_addr = cur.maddr;
  assign mem_wdata = cur.wdata;
  assign mem_wdata_hi = cur.wdata_hi;
  assign stack_trap = cur.trap;
  assign irq = cur.irq;

  // Assertions: pointer movement and access addresses
  a_push_incr: assert property (@(posedge clock) disable iff (!rstn) // RULE_02
    (op == SPLC_OP_PUSH && !reg_wr) |=> cur.sp == $past(cur.sp) + WORD_STEP)
    else $error("push did not increment pointer");
  a_pop_decr: assert property (@(posedge clock) disable iff (!rstn) // RULE_02
    (op == SPLC_OP_POP && !reg_wr) |=> cur.sp == $past(cur.sp) - WORD_STEP)
    else $error("pop did not decrement pointer");
  a_pop_addr: assert property (@(posedge clock) disable iff (!rstn) // RULE_02
    (op == SPLC_OP_POP) |=> mem_re && mem_addr == $past(cur.sp) - WORD_STEP)
    else $error("pop address not pre-decremented");
  a_push_addr: assert property (@(posedge clock) disable iff (!rstn) // RULE_01
    (op == SPLC_OP_PUSH) |=> mem_we && mem_addr == $past(cur.sp))
    else $error("push address wrong");
  a_sp_even: assert property (@(posedge clock) disable iff (!rstn) // RULE_01
    cur.sp[0] == 1'b0)
    else $error("pointer not word aligned");
  a_sp_write: assert property (@(posedge clock) disable iff (!rstn) // RULE_01
    (reg_wr && reg_addr == ADDR_SP && op == SPLC_OP_NONE)
      |=> cur.sp == ($past(reg_wdata) & ALIGN_MASK))
    else $error("pointer write not taken");
  a_idle_quiet: assert property (@(posedge clock) disable iff (!rstn) // RULE_07
    (op == SPLC_OP_NONE) |=> !stack_trap && !mem_we && !mem_re)
    else $error("activity without a stack operation");
  a_ea_addr: assert property (@(posedge clock) disable iff (!rstn) // RULE_07
    (op == SPLC_OP_EA) |=> mem_addr == ($past(ea_addr) & ALIGN_MASK) && !mem_we && !mem_re)
    else $error("pointer address not passed on");
  // Upper limit
  a_at_limit: assert property (@(posedge clock) disable iff (!rstn) // RULE_08
    (op == SPLC_OP_PUSH && cur.sp == cur.limit && cur.sp >= SP_FLOOR) |=> !stack_trap)
    else $error("trap at limit");
  a_over_limit: assert property (@(posedge clock) disable iff (!rstn) // RULE_08
    (op == SPLC_OP_PUSH && cur.sp > cur.limit) |=> stack_trap && cur.fault)
    else $error("missing overflow trap");
  a_over_stat: assert property (@(posedge clock) disable iff (!rstn) // RULE_08
    (op == SPLC_OP_PUSH && cur.sp > cur.limit) |=> cur.ev_stat[EV_OVER])
    else $error("overflow event not recorded");
  a_ea_over: assert property (@(posedge clock) disable iff (!rstn) // RULE_07
    (op == SPLC_OP_EA && (ea_addr & ALIGN_MASK) > cur.limit) |=> stack_trap && cur.fault)
    else $error("pointer address over limit not trapped");
  a_pop_over: assert property (@(posedge clock) disable iff (!rstn) // RULE_07
    (op == SPLC_OP_POP && cur.sp - WORD_STEP > cur.limit) |=> stack_trap)
    else $error("pop address over limit not trapped");
  // Fixed floor
  a_floor_trap: assert property (@(posedge clock) disable iff (!rstn) // RULE_09
    (op == SPLC_OP_EA && ea_addr < SP_FLOOR) |=> stack_trap)
    else $error("missing underflow trap");
  a_push_floor: assert property (@(posedge clock) disable iff (!rstn) // RULE_09
    (op == SPLC_OP_PUSH && cur.sp < SP_FLOOR) |=> stack_trap)
    else $error("push below floor not trapped");
  a_pop_floor: assert property (@(posedge clock) disable iff (!rstn) // RULE_09
    (op == SPLC_OP_POP && cur.sp == SP_FLOOR) |=> stack_trap)
    else $error("pop below floor not trapped");
  a_under_stat: assert property (@(posedge clock) disable iff (!rstn) // RULE_09
    (op == SPLC_OP_PUSH && cur.sp < SP_FLOOR) |=> cur.ev_stat[EV_UNDER])
    else $error("underflow event not recorded");
  // Limit register
  a_limit_even: assert property (@(posedge clock) disable iff (!rstn) // RULE_06
    reg_rd && reg_addr == ADDR_LIMIT |=> reg_rdata[0] == 1'b0)
    else $error("limit bit zero set");
  a_limit_write: assert property (@(posedge clock) disable iff (!rstn) // RULE_06
    (reg_wr && reg_addr == ADDR_LIMIT) |=> cur.limit == ($past(reg_wdata) & ALIGN_MASK))
    else $error("limit write not aligned");
  // Fault flag
  a_fault_set: assert property (@(posedge clock) disable iff (!rstn) // RULE_11
    stack_trap |-> cur.fault)
    else $error("trap without fault flag");
  a_trap_read: assert property (@(posedge clock) disable iff (!rstn) // RULE_11
    (reg_rd && reg_addr == ADDR_TRAP) |=> reg_rdata[FAULT_BIT] == $past(cur.fault))
    else $error("fault flag read back wrong");
  a_fault_hold: assert property (@(posedge clock) disable iff (!rstn) // RULE_12
    (cur.fault && !(reg_wr && reg_addr == ADDR_TRAP)) |=> cur.fault)
    else $error("fault flag dropped");
  a_fault_clear: assert property (@(posedge clock) disable iff (!rstn) // RULE_12
    (reg_wr && reg_addr == ADDR_TRAP && !reg_wdata[FAULT_BIT] && op == SPLC_OP_NONE)
      |=> !cur.fault)
    else $error("fault flag not cleared by write");
  // Pushed word format
  a_call_top: assert property (@(posedge clock) disable iff (!rstn) // RULE_03
    (op == SPLC_OP_PUSH && push_src == SPLC_SRC_CALL) |=> mem_wdata_hi[15:PC_TOP+1] == 9'h0)
    else $error("call push top not clear");
  a_call_pc: assert property (@(posedge clock) disable iff (!rstn) // RULE_03
    (op == SPLC_OP_PUSH && push_src == SPLC_SRC_CALL)
      |=> mem_wdata_hi[PC_TOP:0] == $past(pc[22:16]))
    else $error("call push counter top wrong");
  a_pc_lsb: assert property (@(posedge clock) disable iff (!rstn) // RULE_03
    (op == SPLC_OP_PUSH && push_src != SPLC_SRC_DATA) |=> mem_wdata == {$past(pc[15:1]), 1'b0})
    else $error("counter push low word wrong");
  a_exc_status: assert property (@(posedge clock) disable iff (!rstn) // RULE_04
    (op == SPLC_OP_PUSH && push_src == SPLC_SRC_EXC)
      |=> mem_wdata_hi[15:8] == $past(status_low_byte))
    else $error("exception push lacks status");
  a_exc_pc: assert property (@(posedge clock) disable iff (!rstn) // RULE_04
    (op == SPLC_OP_PUSH && push_src == SPLC_SRC_EXC)
      |=> mem_wdata_hi[PC_TOP+1:0] == {1'b0, $past(pc[22:16])})
    else $error("exception push counter top wrong");
  a_data_push: assert property (@(posedge clock) disable iff (!rstn) // RULE_02
    (op == SPLC_OP_PUSH && push_src == SPLC_SRC_DATA) |=> mem_wdata == $past(push_data))
    else $error("data push word wrong");
endmodule : splc_stack_limit

// ---- splc_seq_model.sv ----
`timescale 1ns/1ps
// Processor sequencer model: replays one bench command per cycle onto the stack port
module splc_seq_model import splc_pkg::*; (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Command from the bench
  input wire splc_op_t c_op,
  input wire splc_src_t c_src,
  input wire logic [15:0] c_data,
  input wire logic [22:0] c_pc,
  input wire logic [7:0] c_srl,
  input wire logic [15:0] c_ea,
  // Stack port toward the block
  output splc_op_t op,
  output splc_src_t push_src,
  output logic [15:0] push_data,
  output logic [22:0] pc,
  output logic [7:0] status_low_byte,
  output logic [15:0] ea_addr
);
  // Launch after the edge, hold one cycle; idle push_data and ea_addr toggle so stale values never match
  always_ff @(posedge clock) begin
    if (!rstn) begin
      op <= SPLC_OP_NONE;
    end else begin
      op <= c_op;
    end
    push_src <= c_src;
    pc <= c_pc;
    status_low_byte <= c_srl;
    push_data <= (c_op == SPLC_OP_NONE) ? ~push_data : c_data;
    ea_addr <= (c_op == SPLC_OP_NONE) ? ~ea_addr : c_ea;
  end
endmodule : splc_seq_model

// ---- splc_stack_limit_tb.sv ----
`timescale 1ns/1ps
// Self-checking bench for the stack limit checker
module splc_stack_limit_tb import splc_pkg::*; ;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata, mem_addr, mem_wdata, mem_wdata_hi, push_data, ea_addr;
  logic mem_we, mem_re, stack_trap, irq;
  splc_op_t op;
  splc_src_t push_src;
  logic [22:0] pc;
  logic [7:0] status_low_byte;
  // Sequencer commands
  splc_op_t c_op = SPLC_OP_NONE;
  splc_src_t c_src = SPLC_SRC_DATA;
  logic [15:0] c_data = 16'h5a5a;
  logic [22:0] c_pc = 23'h7f1235;
  logic [7:0] c_srl = 8'ha5;
  logic [15:0] c_ea = 16'h0000;
  int err_count = 0;
  int checked = 0;
  int cycles = 0;

  splc_seq_model seq (.clock(clock), .rstn(rstn), .c_op(c_op), .c_src(c_src), .c_data(c_data),
    .c_pc(c_pc), .c_srl(c_srl), .c_ea(c_ea), .op(op), .push_src(push_src),
    .push_data(push_data), .pc(pc), .status_low_byte(status_low_byte), .ea_addr(ea_addr));
  splc_stack_limit uut (.clock(clock), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .op(op), .push_src(push_src),
    .push_data(push_data), .pc(pc), .status_low_byte(status_low_byte), .ea_addr(ea_addr),
    .mem_we(mem_we), .mem_re(mem_re), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_wdata_hi(mem_wdata_hi), .stack_trap(stack_trap), .irq(irq));

  // Clock at 5 ns period
  initial begin
    forever #2.5 clock = ~clock;
  end

  // Hang guard
  always @(posedge clock) begin
    cycles++;
    if (cycles == 2000) begin
      err_count++;
      tally_and_finish();
    end
  end

  // Verdict and end of run
  task automatic tally_and_finish();
    if (err_count == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish

  // Compare one value
  task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // One-cycle register write
  task automatic wr(logic [3:0] a, logic [15:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr

  // Read and compare the data standing the cycle after the strobe
  task automatic rd(logic [3:0] a, logic [15:0] exp);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 chk("reg_rdata", exp, reg_rdata);
  endtask : rd

  // One stack operation; memory answer and trap checked the cycle after the block takes it
  task automatic sop(splc_op_t o, splc_src_t s, logic [15:0] ea, logic [15:0] ad, logic tr);
    @(posedge clock);
    c_op <= o;
    c_src <= s;
    c_ea <= ea;
    @(posedge clock);
    c_op <= SPLC_OP_NONE;
    @(posedge clock);
    #1 chk("stack_trap", {15'h0, tr}, {15'h0, stack_trap});
    if (o != SPLC_OP_EA) chk("mem_addr", ad, mem_addr);
    if (o == SPLC_OP_PUSH) chk("mem_we", 16'h1, {15'h0, mem_we});
    if (o == SPLC_OP_POP) chk("mem_re", 16'h1, {15'h0, mem_re});
  endtask : sop

  // Reset values, limit alignment, unmapped index
  task automatic t_reset();
    rd(ADDR_SP, SP_RESET);
    rd(ADDR_TRAP, ZERO16);
    rd(4'hf, ZERO16);
    wr(ADDR_LIMIT, 16'h0803);
    rd(ADDR_LIMIT, 16'h0802);
  endtask : t_reset

  // Push up to and past the limit, then pop
  task automatic t_limit();
    sop(SPLC_OP_PUSH, SPLC_SRC_DATA, 16'h0, 16'h0800, 1'b0);
    chk("mem_wdata", 16'h5a5a, mem_wdata);
    sop(SPLC_OP_PUSH, SPLC_SRC_DATA, 16'h0, 16'h0802, 1'b0);
    sop(SPLC_OP_PUSH, SPLC_SRC_DATA, 16'h0, 16'h0804, 1'b1);
    rd(ADDR_SP, 16'h0806);
    rd(ADDR_TRAP, 16'h0004);
    rd(ADDR_TRAP, 16'h0004);
    sop(SPLC_OP_POP, SPLC_SRC_DATA, 16'h0, 16'h0804, 1'b1);
    rd(ADDR_SP, 16'h0804);
  endtask : t_limit

  // Masking and read-to-clear of the event status
  task automatic t_irq();
    chk("irq", 16'h0, {15'h0, irq});
    wr(ADDR_IRQ_MASK, 16'h0001);
    #1 chk("irq", 16'h1, {15'h0, irq});
    rd(ADDR_IRQ_STAT, 16'h0001);
    #1 chk("irq", 16'h0, {15'h0, irq});
    wr(ADDR_TRAP, ZERO16);
    rd(ADDR_TRAP, ZERO16);
    wr(ADDR_LIMIT, 16'h0ffe);
    wr(ADDR_SP, 16'h07fe);
    sop(SPLC_OP_PUSH, SPLC_SRC_DATA, 16'h0, 16'h07fe, 1'b1);
    sop(SPLC_OP_POP, SPLC_SRC_DATA, 16'h0, 16'h07fe, 1'b1);
    #1 chk("irq", 16'h0, {15'h0, irq});
    rd(ADDR_IRQ_STAT, 16'h0002);
    rd(ADDR_IRQ_MASK, 16'h0001);
  endtask : t_irq

  // Counter push formats and pointer-based address checks
  task automatic t_pc_ea();
    wr(ADDR_SP, 16'h0900);
    wr(ADDR_TRAP, ZERO16);
    sop(SPLC_OP_PUSH, SPLC_SRC_CALL, 16'h0, 16'h0900, 1'b0);
    chk("mem_wdata", 16'h1234, mem_wdata);
    chk("mem_wdata_hi", 16'h007f, mem_wdata_hi);
    wr(ADDR_SP, 16'h0900);
    sop(SPLC_OP_PUSH, SPLC_SRC_EXC, 16'h0, 16'h0900, 1'b0);
    chk("mem_wdata_hi", 16'ha57f, mem_wdata_hi);
    // No pointer access right after a limit write in this sequence
    sop(SPLC_OP_EA, SPLC_SRC_DATA, 16'h0ffd, 16'h0, 1'b0);
    sop(SPLC_OP_EA, SPLC_SRC_DATA, 16'h1001, 16'h0, 1'b1);
    sop(SPLC_OP_EA, SPLC_SRC_DATA, 16'h07ff, 16'h0, 1'b1);
    rd(ADDR_TRAP, 16'h0004);
  endtask : t_pc_ea

  // Main sequence
  initial begin
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    t_reset();
    t_limit();
    t_irq();
    t_pc_ea();
    tally_and_finish();
  end
endmodule : splc_stack_limit_tb
